/* include/readout_regs_pkg.sv */
package readout_regs_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and register indices (byte address = index * 4).
  // ----------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam logic [15:0] IDX_BP_MAP = 16'h5107;
  localparam logic [15:0] IDX_LOC_ID = 16'h5108;
  localparam logic [15:0] IDX_SCAN_DLY = 16'h510A;
  localparam logic [15:0] IDX_ERR_A = 16'h5110;
  localparam logic [15:0] IDX_ERR_B = 16'h5111;
  localparam logic [15:0] IDX_SC_DIV = 16'h800C;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h5140;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h5141;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field widths, positions and reset values.
  // ----------------------------------------------------------------
  localparam int LOC_W = 9;
  localparam int LOC_SIDE_BIT = 8;
  localparam int LOC_SECTOR_LO = 3;
  localparam int LOC_PART_LO = 0;
  localparam logic [8:0] RST_LOC_ID = 9'h000;
  localparam int DLY_W = 13;
  localparam logic [12:0] RST_SCAN_DELAY = 13'hE10;
  localparam int SC_CODE_W = 2;
  localparam logic [1:0] RST_SC_CODE = 2'h0;
  localparam int ERR_W = 20;
  localparam int ERR_CHIP_BIT = 0;
  localparam int ERR_WR_LO = 1;
  localparam int ERR_RD_LO = 8;
  localparam int ERR_RDO_WR_BIT = 15;
  localparam int ERR_RDO_LO = 16;
  localparam int IRQ_W = 3;
  localparam int IRQ_ERR_A = 0;
  localparam int IRQ_ERR_B = 1;
  localparam int IRQ_SCAN_DONE = 2;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

  // ----------------------------------------------------------------
  // Timing constants.
  // ----------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 4;
  localparam int SCAN_TICK_NS = 25;
  localparam int SC_FAST_FREQ_KHZ = 5000;
  localparam int SC_FAST_HALF_NS = 1000000 / (2 * SC_FAST_FREQ_KHZ);

  // Scan sequencer states.
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b01,
    SCAN_WAIT = 2'b10
  } scan_state_t;

endpackage

/* rtl/rate_tick.sv */
`timescale 1ns/10ps
`default_nettype none
module rate_tick #(
  parameter int STEP = 4,
  parameter int MODULUS = 25
) (
  input wire logic sys_clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  output logic tick // One-cycle pulse every MODULUS/STEP clocks on average.
);
  // ----------------------------------------------------------------
  // Fractional accumulator.
  // ----------------------------------------------------------------
  localparam int AW = $clog2(MODULUS + STEP) + 1;
  logic [AW-1:0] acc; // Phase accumulator in units of STEP.
  wire logic [AW-1:0] sum = acc + AW'(STEP);
  wire logic wrap = (sum >= AW'(MODULUS));

  // Periods that are not whole clocks alternate between two spacings.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      tick <= 1'b0;
    end else begin
      acc <= wrap ? sum - AW'(MODULUS) : sum;
      tick <= wrap;
    end
  end

  a_tick_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (MODULUS > STEP) && tick |=> !tick)
    else $error("Tick pulse lasted more than one cycle.");
endmodule
`default_nettype wire

/* rtl/error_latch.sv */
`timescale 1ns/10ps
`default_nettype none
module error_latch
  import readout_regs_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic chipError, // Front-end chip error line, high active.
  input wire logic [6:0] wrFault, // Write machine fault pulses.
  input wire logic [6:0] rdFault, // Read machine fault pulses.
  input wire logic wrFromReadout, // Write transaction owned by readout machine.
  input wire logic [3:0] rdoFault, // Event readout fault pulses.
  input wire logic clear, // Clear request from a register read.
  output logic [19:0] errorCode, // Sticky error code.
  output logic newError // Some error bit is being set this cycle.
);
  // ----------------------------------------------------------------
  // Event vector in register layout.
  // ----------------------------------------------------------------
  // readout write failure
  wire logic rdoWrFail = wrFromReadout & (|wrFault);
  wire logic [ERR_W-1:0] setVec = {rdoFault, rdoWrFail, rdFault, wrFault, chipError};
  assign newError = |setVec;

  // A set in the clearing cycle survives the clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      errorCode <= '0;
    end else begin
      errorCode <= (clear ? '0 : errorCode) | setVec;
    end
  end

  a_chip_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    chipError |=> errorCode[ERR_CHIP_BIT])
    else $error("Chip error line not recorded.");
  a_wr_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wrFault != 7'h00 |=> (errorCode[7:1] & $past(wrFault)) == $past(wrFault))
    else $error("Write machine fault not recorded.");
  a_rd_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rdFault != 7'h00 |=> (errorCode[14:8] & $past(rdFault)) == $past(rdFault))
    else $error("Read machine fault not recorded.");
  a_rdo_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wrFromReadout && (wrFault != 7'h00) |=> errorCode[ERR_RDO_WR_BIT])
    else $error("Readout write failure bit wrong.");
  a_rdo_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clear && !errorCode[ERR_RDO_WR_BIT] && !(wrFromReadout && (wrFault != 7'h00))
      |=> !errorCode[ERR_RDO_WR_BIT])
    else $error("Readout write failure bit set without cause.");
  a_rdo_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rdoFault != 4'h0 |=> (errorCode[19:16] & $past(rdoFault)) == $past(rdoFault))
    else $error("Event readout fault not recorded.");
endmodule
`default_nettype wire

/* rtl/readout_config_regs.sv */
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Backplane bit selects card list mapping.
// - Nine-bit location: side, sector, partition.
// - Broadcast scan command, then wait delay.
// - Thirteen-bit delay in 25 ns, reset 0xE10.
// - Slow clock 5/2.5/1.25/0.625 MHz by code.
// - Error bit 0 records chip error line.
// - Bits 1-7 record write machine faults.
// - Bits 8-14 record read machine faults.
// - Bit 15: readout-started write failed.
// - Bits 16-19 record event readout faults.
module readout_config_regs
  import readout_regs_pkg::*;
#(
  parameter int CARDS = 32
) (
  input wire logic sys_clk, // System clock, 250 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [17:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [17:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic irq, // Level interrupt, high active.
  input wire logic backplaneStrap, // Backplane version strap.
  input wire logic [CARDS-1:0] activeCardList, // Cards to power, A low half.
  output logic [CARDS-1:0] cardSwitch, // Card switch lines.
  output logic [8:0] unitLocationId, // Location identifier.
  input wire logic sparseScanStart, // Readout machine requests a scan.
  output logic scanCmdStrobe, // One-cycle broadcast of the scan command.
  output logic scanBusy, // Waiting out the scan delay.
  output logic scanDone, // One-cycle pulse when the delay has elapsed.
  output logic slowClk, // Slow-control clock to board controllers.
  input wire logic chipErrorA, // Branch A chip error line.
  input wire logic [6:0] wrFaultA, // Branch A write machine faults.
  input wire logic [6:0] rdFaultA, // Branch A read machine faults.
  input wire logic wrFromReadoutA, // Branch A write owned by readout machine.
  input wire logic [3:0] rdoFaultA, // Branch A event readout faults.
  input wire logic chipErrorB, // Branch B chip error line.
  input wire logic [6:0] wrFaultB, // Branch B write machine faults.
  input wire logic [6:0] rdFaultB, // Branch B read machine faults.
  input wire logic wrFromReadoutB, // Branch B write owned by readout machine.
  input wire logic [3:0] rdoFaultB // Branch B event readout faults.
);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] wrAddr; // Captured write address.
  logic [31:0] wrData; // Captured write data.
  logic [3:0] wrStrb; // Captured write strobes.
  logic bpMode; // Backplane mapping bit.
  logic strapTaken; // Strap has been sampled after reset.
  logic [DLY_W-1:0] scanDelay; // Scan delay in 25 ns ticks.
  logic [SC_CODE_W-1:0] scCode; // Slow clock rate code.
  logic [IRQ_W-1:0] irqStatus; // Sticky event bits.
  logic [IRQ_W-1:0] irqMask; // Interrupt enables.
  scan_state_t scanState; // Scan sequencer state.
  logic [DLY_W-1:0] scanCount; // Remaining scan ticks.
  logic [2:0] halfCnt; // Base ticks in current slow clock half.
  logic [ERR_W-1:0] errCodeA; // Branch A error code.
  logic [ERR_W-1:0] errCodeB; // Branch B error code.
  logic newErrA; // Branch A error event.
  logic newErrB; // Branch B error event.
  logic scanTick; // 25 ns tick.
  logic [4:0] scanPhase; // Nanoseconds elapsed in the current 25 ns tick.
  logic baseTick; // Half period tick of the fastest slow clock.

  // ----------------------------------------------------------------
  // Write channel decode.
  // ----------------------------------------------------------------
  wire logic awHs = s_axi_awvalid & s_axi_awready;
  wire logic wHs = s_axi_wvalid & s_axi_wready;
  wire logic doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire logic [15:0] wrIdx = wrAddr[ADDR_W-1:2];
  wire logic wrHitLoc = doWrite && (wrIdx == IDX_LOC_ID);
  wire logic wrHitDly = doWrite && (wrIdx == IDX_SCAN_DLY);
  wire logic wrHitSc = doWrite && (wrIdx == IDX_SC_DIV);
  wire logic wrHitMask = doWrite && (wrIdx == IDX_IRQ_MASK);
  wire logic wrKnown = (wrIdx == IDX_LOC_ID) || (wrIdx == IDX_SCAN_DLY)
    || (wrIdx == IDX_SC_DIV) || (wrIdx == IDX_IRQ_MASK) || (wrIdx == IDX_BP_MAP)
    || (wrIdx == IDX_ERR_A) || (wrIdx == IDX_ERR_B) || (wrIdx == IDX_IRQ_STATUS);
  // Byte lanes enabled by the captured strobes; lanes left out keep their old value.
  wire logic [31:0] strbMask = {{8{wrStrb[3]}}, {8{wrStrb[2]}}, {8{wrStrb[1]}}, {8{wrStrb[0]}}};
  wire logic [31:0] locMerged = ({23'h000000, unitLocationId} & ~strbMask) | (wrData & strbMask);
  wire logic [31:0] dlyMerged = ({19'h00000, scanDelay} & ~strbMask) | (wrData & strbMask);
  wire logic [31:0] scMerged = ({30'h00000000, scCode} & ~strbMask) | (wrData & strbMask);
  wire logic [31:0] maskMerged = ({29'h00000000, irqMask} & ~strbMask) | (wrData & strbMask);

  // Address and data are taken in either order; the write fires once both are held.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wrAddr <= '0;
      wrData <= 32'h00000000;
      wrStrb <= 4'h0;
    end else begin
      if (awHs) begin
        wrAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (wHs) begin
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrKnown ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Writable configuration registers.
  // ----------------------------------------------------------------
  // Read-only registers ignore writes but still answer OKAY.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      unitLocationId <= RST_LOC_ID;
      scanDelay <= RST_SCAN_DELAY;
      scCode <= RST_SC_CODE;
      irqMask <= RST_IRQ_MASK;
    end else begin
      if (wrHitLoc) begin
        unitLocationId <= locMerged[LOC_W-1:0];
      end
      if (wrHitDly) begin
        scanDelay <= dlyMerged[DLY_W-1:0];
      end
      if (wrHitSc) begin
        scCode <= scMerged[SC_CODE_W-1:0];
      end
      if (wrHitMask) begin
        irqMask <= maskMerged[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel decode and selection.
  // ----------------------------------------------------------------
  wire logic arHs = s_axi_arvalid & s_axi_arready;
  wire logic [15:0] rdIdx = s_axi_araddr[ADDR_W-1:2];
  wire logic rdBp = (rdIdx == IDX_BP_MAP);
  wire logic rdLoc = (rdIdx == IDX_LOC_ID);
  wire logic rdDly = (rdIdx == IDX_SCAN_DLY);
  wire logic rdErrA = (rdIdx == IDX_ERR_A);
  wire logic rdErrB = (rdIdx == IDX_ERR_B);
  wire logic rdSc = (rdIdx == IDX_SC_DIV);
  wire logic rdStat = (rdIdx == IDX_IRQ_STATUS);
  wire logic rdMask = (rdIdx == IDX_IRQ_MASK);
  wire logic rdKnown = rdBp | rdLoc | rdDly | rdErrA | rdErrB | rdSc | rdStat | rdMask;
  wire logic [31:0] readWord =
    rdBp ? {31'h00000000, bpMode} :
    rdLoc ? {23'h000000, unitLocationId} :
    rdDly ? {19'h00000, scanDelay} :
    rdErrA ? {12'h000, errCodeA} :
    rdErrB ? {12'h000, errCodeB} :
    rdSc ? {30'h00000000, scCode} :
    rdStat ? {29'h00000000, irqStatus} :
    rdMask ? {29'h00000000, irqMask} : 32'h00000000;
  wire logic clrErrA = arHs && rdErrA;
  wire logic clrErrB = arHs && rdErrB;
  wire logic clrStat = arHs && rdStat;

  // Data is sampled at the address handshake, so a read-clear never loses it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (arHs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readWord;
      s_axi_rresp <= rdKnown ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Backplane mapping.
  // ----------------------------------------------------------------
  // The strap is caught on the first edge after reset release.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bpMode <= 1'b0;
      strapTaken <= 1'b0;
    end else if (!strapTaken) begin
      bpMode <= backplaneStrap;
      strapTaken <= 1'b1;
    end
  end

  wire logic [CARDS-1:0] swappedList = {activeCardList[CARDS/2-1:0],
                                        activeCardList[CARDS-1:CARDS/2]};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cardSwitch <= '0;
    end else begin
      cardSwitch <= bpMode ? swappedList : activeCardList;
    end
  end

  // ----------------------------------------------------------------
  // Scan event length sequencer.
  // ----------------------------------------------------------------
  // The tick phase restarts with each scan, so the wait is exact to one clock.
  wire logic [5:0] phaseSum = {1'b0, scanPhase} + 6'(SYS_CLK_PERIOD_NS);
  assign scanTick = scanBusy && (phaseSum >= 6'(SCAN_TICK_NS));
  wire logic scanFinish = (scanState == SCAN_WAIT) && (scanCount == '0);
  assign scanBusy = scanState[1];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scanState <= SCAN_IDLE;
      scanCount <= '0;
      scanPhase <= 5'h00;
      scanCmdStrobe <= 1'b0;
      scanDone <= 1'b0;
    end else begin
      scanCmdStrobe <= 1'b0;
      scanDone <= 1'b0;
      unique case (scanState)
        SCAN_IDLE: begin
          if (sparseScanStart) begin
            scanCmdStrobe <= 1'b1;
            scanCount <= scanDelay;
            scanPhase <= 5'h00;
            scanState <= SCAN_WAIT;
          end
        end
        SCAN_WAIT: begin
          scanPhase <= scanTick ? 5'(phaseSum - 6'(SCAN_TICK_NS)) : phaseSum[4:0];
          if (scanFinish) begin
            scanDone <= 1'b1;
            scanState <= SCAN_IDLE;
          end else if (scanTick) begin
            scanCount <= scanCount - 13'h0001;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Slow-control clock.
  // ----------------------------------------------------------------
  rate_tick #(.STEP(SYS_CLK_PERIOD_NS), .MODULUS(SC_FAST_HALF_NS)) slowTicker (
    .sys_clk(sys_clk), .rst_n(rst_n), .tick(baseTick)
  );

  wire logic [2:0] halfLimit = 3'((4'h1 << scCode) - 4'h1);
  wire logic halfEnd = baseTick && (halfCnt >= halfLimit);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      halfCnt <= 3'h0;
      slowClk <= 1'b0;
    end else if (halfEnd) begin
      halfCnt <= 3'h0;
      slowClk <= !slowClk;
    end else if (baseTick) begin
      halfCnt <= halfCnt + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Branch error codes.
  // ----------------------------------------------------------------
  // one latch per branch
  error_latch errLatchA (
    .sys_clk(sys_clk), .rst_n(rst_n), .chipError(chipErrorA), .wrFault(wrFaultA),
    .rdFault(rdFaultA), .wrFromReadout(wrFromReadoutA), .rdoFault(rdoFaultA),
    .clear(clrErrA), .errorCode(errCodeA), .newError(newErrA)
  );

  error_latch errLatchB (
    .sys_clk(sys_clk), .rst_n(rst_n), .chipError(chipErrorB), .wrFault(wrFaultB),
    .rdFault(rdFaultB), .wrFromReadout(wrFromReadoutB), .rdoFault(rdoFaultB),
    .clear(clrErrB), .errorCode(errCodeB), .newError(newErrB)
  );

  // ----------------------------------------------------------------
  // Interrupt status and output.
  // ----------------------------------------------------------------
  wire logic [IRQ_W-1:0] irqSet = {scanDone, newErrB, newErrA};

  // Events set status bits; a status read clears them unless set again.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus <= '0;
      irq <= 1'b0;
    end else begin
      irqStatus <= (clrStat ? '0 : irqStatus) | irqSet;
      irq <= |(irqStatus & irqMask);
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  a_bp_mapping: assert property (@(posedge sys_clk) disable iff (!rst_n)
    strapTaken |=> cardSwitch == ($past(bpMode) ? $past(swappedList) : $past(activeCardList)))
    else $error("Card switch mapping wrong.");
  a_loc_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wrHitLoc && wrStrb == 4'hF |=> unitLocationId == $past(wrData[8:0]))
    else $error("Location identifier not stored.");
  a_scan_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scanState == SCAN_IDLE && sparseScanStart |=> scanCmdStrobe && scanBusy
      && scanCount == $past(scanDelay))
    else $error("Scan command not broadcast.");
  a_scan_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
    scanBusy && scanCount != '0 && scanTick |=> scanCount == $past(scanCount) - 13'h0001)
    else $error("Scan delay not counting.");
  a_dly_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> scanDelay == RST_SCAN_DELAY)
    else $error("Scan delay reset value wrong.");
  a_slow_toggle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    halfEnd |=> slowClk != $past(slowClk) && halfCnt == 3'h0)
    else $error("Slow clock did not toggle.");
  a_branch_apart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !newErrB && !clrErrB |=> $stable(errCodeB))
    else $error("Branch B code changed without cause.");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (irqStatus & irqMask) != '0 |=> irq)
    else $error("Interrupt not raised.");

  c_scan_done: cover property (@(posedge sys_clk) disable iff (!rst_n) scanDone);
  c_err_both: cover property (@(posedge sys_clk) disable iff (!rst_n) newErrA && newErrB);
  c_slow_slowest: cover property (@(posedge sys_clk) disable iff (!rst_n)
    halfEnd && scCode == 2'h3);

endmodule
`default_nettype wire

/* tb/front_end_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Board controller side: replays a requested fault pattern one cycle later.
module front_end_model (
  input wire logic sys_clk, // System clock.
  input wire logic [19:0] injA, // Pattern for branch A.
  input wire logic [19:0] injB, // Pattern for branch B.
  output logic [19:0] lineA, // Fault lines of branch A.
  output logic [19:0] lineB // Fault lines of branch B.
);
  // Each branch has its own lines, so faults never cross over.
  always_ff @(posedge sys_clk) begin
    lineA <= injA;
    lineB <= injB;
  end
endmodule
`default_nettype wire

/* tb/readout_ctrl_config_error_regs_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module readout_ctrl_config_error_regs_bench;
  import readout_regs_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, start = 1'b0, strap = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [17:0] awaddr = 18'h0, araddr = 18'h0;
  logic [31:0] wdata = 32'h0, cardList = 32'h1234ABCD, rdata, cardSwitch, got;
  logic awready, wready, bvalid, arready, rvalid, irq, sclk, strobe, busy, done;
  logic [1:0] bresp, rresp, resp;
  logic [8:0] locId;
  logic [19:0] injA = 20'h0, injB = 20'h0, lineA, lineB;
  int bad_count = 0, check_count = 0, cycles = 0;
  time t0;
  readout_config_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
    .backplaneStrap(strap), .activeCardList(cardList), .cardSwitch(cardSwitch),
    .unitLocationId(locId), .sparseScanStart(start), .scanCmdStrobe(strobe),
    .scanBusy(busy), .scanDone(done), .slowClk(sclk), .chipErrorA(lineA[0]),
    .wrFaultA(lineA[7:1]), .rdFaultA(lineA[14:8]), .wrFromReadoutA(lineA[15]),
    .rdoFaultA(lineA[19:16]), .chipErrorB(lineB[0]), .wrFaultB(lineB[7:1]),
    .rdFaultB(lineB[14:8]), .wrFromReadoutB(lineB[15]), .rdoFaultB(lineB[19:16]));
  front_end_model u_far (.sys_clk(sys_clk), .injA(injA), .injB(injB), .lineA(lineA),
    .lineB(lineB));
  always #2 sys_clk = ~sys_clk;
  // Prints the verdict and ends the run.
  task complete_run();
    $display("checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Compares one value with case equality.
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // AXI4-Lite write; each channel is dropped at its own handshake.
  task wr(input logic [17:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask
  // AXI4-Lite read.
  task rd(input logic [17:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    got = rdata;
    resp = rresp;
  endtask
  // A hang is cut short here and counted as a mismatch.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(18'h1441C);
    chk("mapping", 32'h0, got);
    chk("cardSwitch", cardList, cardSwitch);
    rd(18'h14428);
    chk("delay", 32'hE10, got);
    wr(18'h14420, 32'hFFFFFFAB);
    chk("writeResp", {30'h0, RESP_OKAY}, {30'h0, resp});
    rd(18'h14420);
    chk("location", 32'h1AB, got);
    chk("locationPins", 32'h1AB, {23'h0, locId});
    rd(18'h00010);
    chk("unmappedResp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    wr(18'h14428, 32'h8);
    @(posedge sys_clk) start <= 1'b1;
    @(posedge strobe) t0 = $time;
    start <= 1'b0;
    #1 chk("busy", 32'h1, {31'h0, busy});
    @(posedge done) got = 32'(($time - t0) / 4);
    chk("scanWait", 32'h1, {31'h0, got >= 49 && got <= 53});
    for (int c = 0; c < 4; c++) begin
      wr(18'h20030, 32'(c));
      @(posedge sclk);
      @(posedge sclk) t0 = $time;
      @(negedge sclk) chk("halfPeriod", 32'(25 << c), 32'(($time - t0) / 4));
    end
    wr(18'h14504, 32'h3);
    @(posedge sys_clk) injA <= 20'hFFFFF;
    injB <= 20'h00100;
    @(posedge sys_clk) injA <= 20'h0;
    injB <= 20'h0;
    repeat (4) @(posedge sys_clk);
    chk("irqHigh", 32'h1, {31'h0, irq});
    rd(18'h14440);
    chk("errA", 32'hFFFFF, got);
    rd(18'h14444);
    chk("errB", 32'h00100, got);
    rd(18'h14440);
    chk("errAcleared", 32'h0, got);
    rd(18'h14500);
    chk("status", 32'h7, got);
    repeat (3) @(posedge sys_clk);
    chk("irqLow", 32'h0, {31'h0, irq});
    // A second reset with the strap high selects the alternate card mapping.
    strap <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(18'h1441C);
    chk("mappingAlt", 32'h1, got);
    chk("cardSwitchAlt", 32'hABCD1234, cardSwitch);
    rd(18'h14428);
    chk("delayAgain", 32'hE10, got);
    complete_run();
  end
endmodule
`default_nettype wire
